// *** common/diag_defs.svh ***
`ifndef DIAG_DEFS_SVH
`define DIAG_DEFS_SVH

// ==========================================================================
// telegram layout
`define DIAG_TELE_LEN 16
`define DIAG_TB_ST1 4'h0
`define DIAG_TB_ST2 4'h1
`define DIAG_TB_ST3 4'h2
`define DIAG_TB_MASTER 4'h3
`define DIAG_TB_IDENT_HI 4'h4
`define DIAG_TB_IDENT_LO 4'h5
`define DIAG_TB_DEV_HDR 4'h6
`define DIAG_TB_MSG 4'h7
`define DIAG_TB_USER0 4'hb
`define DIAG_TB_LAST 4'hf

// ==========================================================================
// device-specific header and message codes
`define DIAG_DEV_LEN 6'h0a
`define DIAG_DEV_CODE 2'h0
`define DIAG_MSG_NONE 8'h00
`define DIAG_MSG_ERR_FIRST 8'h12
`define DIAG_MSG_ERR_LAST 8'h17
`define DIAG_MSG_USER_VALID 8'h40

// ==========================================================================
// user diagnostic block in the process image
`define DIAG_BLK_LEN 16'h0006
`define DIAG_BLK_STATUS_OFS 3'h0
`define DIAG_BLK_PAYLOAD_OFS 3'h1
`define DIAG_BLK_VALID_BIT 0
`define DIAG_BLK_DELETE_BIT 1
`define DIAG_BLK_IGNORE_VAL 8'h03

// ==========================================================================
// reset values
`define DIAG_STATUS_RST 8'h00
`define DIAG_PAYLOAD_RST 40'h00_0000_0000
`define DIAG_MASTER_RST 8'hff
`define DIAG_IDENT_DEFAULT 16'h0000

`endif

// *** common/diag_pkg.sv ***
`default_nettype none

package diag_pkg;

  // ==========================================================================
  // station condition inputs from the protocol engine
  typedef struct packed {
    logic not_ready;
    logic cfg_mismatch;
    logic unsupported;
    logic wrong_param;
    logic need_param;
    logic static_diag;
    logic resp_mon;
    logic overflow;
  } station_flags_type;

  // ==========================================================================
  // everything needed to assemble one telegram
  typedef struct packed {
    station_flags_type flags;
    logic ext_diag;
    logic freeze_seen;
    logic sync_seen;
    logic [7:0] master_addr;
    logic [15:0] ident;
    logic [7:0] msg_code;
    logic [39:0] payload;
  } tele_fields_type;

  typedef logic [15:0][7:0] telegram_type;

  // ==========================================================================
  // process image access from the cpu
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pi_req_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SEND = 2'b10
  } tx_state_type;

endpackage

`default_nettype wire

// *** hw/diag_telegram_pack.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "diag_defs.svh"

module diag_telegram_pack (
  // fields in
  input wire diag_pkg::tele_fields_type i_fields,
  // assembled telegram out
  output diag_pkg::telegram_type o_tele
);

  // ==========================================================================
  // standard section and fixed header
  always_comb begin
    o_tele = '0; // reserved bytes 8..10 stay zero
    o_tele[`DIAG_TB_ST1] = {1'b0, i_fields.flags.wrong_param, 1'b0, i_fields.flags.unsupported,
                            i_fields.ext_diag, i_fields.flags.cfg_mismatch,
                            i_fields.flags.not_ready, 1'b0};
    o_tele[`DIAG_TB_ST2] = {1'b0, 1'b0, i_fields.sync_seen, i_fields.freeze_seen,
                            i_fields.flags.resp_mon, 1'b1, i_fields.flags.static_diag,
                            i_fields.flags.need_param};
    o_tele[`DIAG_TB_ST3] = {i_fields.flags.overflow, 7'h00};
    o_tele[`DIAG_TB_MASTER] = i_fields.master_addr;
    o_tele[`DIAG_TB_IDENT_HI] = i_fields.ident[15:8];
    o_tele[`DIAG_TB_IDENT_LO] = i_fields.ident[7:0];
    o_tele[`DIAG_TB_DEV_HDR] = {`DIAG_DEV_CODE, `DIAG_DEV_LEN};
    o_tele[`DIAG_TB_MSG] = i_fields.msg_code;
    // user bytes, block byte 1 lands on telegram byte 11
    for (int k = 0; k < 5; k++) begin
      o_tele[`DIAG_TB_USER0 + k] = i_fields.payload[k*8 +: 8];
    end
  end

endmodule
`default_nettype wire

// *** hw/dp_slave_diag_builder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "diag_defs.svh"


module dp_slave_diag_builder #(
  parameter logic [15:0] IDENT_NUM = `DIAG_IDENT_DEFAULT // arbitrary value
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // cpu process image access
  input wire diag_pkg::pi_req_type i_pi,
  input wire logic [15:0] i_diag_base,
  output logic [7:0] o_pi_rdata,
  output logic o_pi_rvalid,
  // protocol engine events
  input wire diag_pkg::station_flags_type i_flags,
  input wire logic i_prm_valid,
  input wire logic [7:0] i_prm_master,
  input wire logic i_freeze_rx,
  input wire logic i_sync_rx,
  input wire logic i_err_valid,
  input wire logic [7:0] i_err_code,
  input wire logic i_err_clear,
  // telegram stream to the link
  input wire logic i_diag_req,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  output logic o_diag_pending
);

  // ==========================================================================
  // state
  logic [7:0] status_q, status_d;
  logic [39:0] payload_q, payload_d;
  logic user_valid_q, user_valid_d;
  logic [7:0] err_q, err_d;
  logic [7:0] master_q, master_d;
  logic freeze_q, freeze_d;
  logic sync_q, sync_d;
  logic pend_q, pend_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  diag_pkg::tx_state_type state_q, state_d;
  logic [3:0] idx_q, idx_d;
  logic valid_q, valid_d;
  logic [7:0] data_q, data_d;
  logic last_q, last_d;
  diag_pkg::telegram_type snap_q, snap_d;

  logic [15:0] ofs;
  logic hit;
  logic status_wr;
  logic [4:0] pay_wr;
  logic start_evt;
  logic err_ok;
  logic sent_done;
  diag_pkg::tele_fields_type fields;
  diag_pkg::telegram_type tele;

  // ==========================================================================
  // process image decode
  always_comb begin
    ofs = i_pi.addr - i_diag_base;
    hit = (i_pi.addr >= i_diag_base) && (ofs < `DIAG_BLK_LEN); // six bytes from base
    status_wr = i_pi.wr && hit && (ofs[2:0] == `DIAG_BLK_STATUS_OFS);
  end

  // one write strobe per user byte
  generate
    for (genvar g = 0; g < 5; g++) begin : g_pay_wr
      assign pay_wr[g] = i_pi.wr && hit && (ofs[2:0] == (`DIAG_BLK_PAYLOAD_OFS + 3'(g)));
    end
  endgenerate

  // ==========================================================================
  // user diagnostic block
  always_comb begin
    status_d = status_q;
    user_valid_d = user_valid_q;
    start_evt = 1'b0;
    if (status_wr && (i_pi.wdata != `DIAG_BLK_IGNORE_VAL)) begin // 03h leaves all alone
      status_d = i_pi.wdata;
      if (i_pi.wdata[`DIAG_BLK_DELETE_BIT]) begin
        user_valid_d = 1'b0; // deletion request
      end else if (!i_pi.wdata[`DIAG_BLK_VALID_BIT]) begin
        user_valid_d = 1'b0; // data marked invalid
      end else if (!status_q[`DIAG_BLK_VALID_BIT]) begin
        user_valid_d = 1'b1; // rising valid bit starts it
        start_evt = 1'b1;
      end
    end
  end

  // payload bytes may be rewritten at any time before a request
  always_comb begin
    payload_d = payload_q;
    for (int k = 0; k < 5; k++) begin
      if (pay_wr[k]) begin
        payload_d[k*8 +: 8] = i_pi.wdata;
      end
    end
  end

  // readback of the block, one cycle later
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = i_pi.rd && hit;
    if (i_pi.rd && hit) begin
      if (ofs[2:0] == `DIAG_BLK_STATUS_OFS) begin
        rdata_d = status_q;
      end else begin
        rdata_d = payload_q[(3'(ofs[2:0] - 3'h1)) * 8 +: 8];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_q <= `DIAG_STATUS_RST;
      payload_q <= `DIAG_PAYLOAD_RST;
      user_valid_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      status_q <= status_d;
      payload_q <= payload_d;
      user_valid_q <= user_valid_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================================
  // protocol events: error code, master address, freeze and sync
  always_comb begin
    err_ok = i_err_valid && (i_err_code >= `DIAG_MSG_ERR_FIRST) && (i_err_code <= `DIAG_MSG_ERR_LAST);
    err_d = err_q;
    if (i_err_clear) begin
      err_d = `DIAG_MSG_NONE;
    end
    if (err_ok) begin
      err_d = i_err_code; // new error beats a clear in the same cycle
    end
    master_d = master_q;
    freeze_d = freeze_q;
    sync_d = sync_q;
    if (i_prm_valid) begin
      master_d = i_prm_master; // address of the parametrizing master
      freeze_d = 1'b0;
      sync_d = 1'b0;
    end
    if (i_freeze_rx) begin
      freeze_d = 1'b1;
    end
    if (i_sync_rx) begin
      sync_d = 1'b1;
    end
  end

  // pending request towards the link, set wins over the send clear
  always_comb begin
    pend_d = pend_q;
    if (sent_done) begin
      pend_d = 1'b0;
    end
    if (start_evt || err_ok) begin
      pend_d = 1'b1; // errors and new user data raise the pending request
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      err_q <= `DIAG_MSG_NONE;
      master_q <= `DIAG_MASTER_RST;
      freeze_q <= 1'b0;
      sync_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      err_q <= err_d;
      master_q <= master_d;
      freeze_q <= freeze_d;
      sync_q <= sync_d;
      pend_q <= pend_d;
    end
  end

  // ==========================================================================
  // telegram assembly
  always_comb begin
    fields.flags = i_flags;
    fields.ext_diag = user_valid_q || (err_q != `DIAG_MSG_NONE);
    fields.freeze_seen = freeze_q;
    fields.sync_seen = sync_q;
    fields.master_addr = master_q;
    fields.ident = IDENT_NUM;
    // an error code outranks the user code so faults are never masked
    if (err_q != `DIAG_MSG_NONE) begin
      fields.msg_code = err_q;
    end else if (user_valid_q) begin
      fields.msg_code = `DIAG_MSG_USER_VALID;
    end else begin
      fields.msg_code = `DIAG_MSG_NONE;
    end
    fields.payload = payload_q;
  end

  diag_telegram_pack u_pack (
    .i_fields(fields),
    .o_tele(tele)
  );

  // ==========================================================================
  // telegram streaming
  // snapshot first so a cpu write mid-telegram cannot tear the bytes
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    snap_d = snap_q;
    sent_done = 1'b0;
    unique case (state_q)
      diag_pkg::TX_IDLE: begin
        if (i_diag_req) begin
          snap_d = tele; // a master request is answered only in TX_IDLE, requests during a send are dropped
          idx_d = 4'h0;
          state_d = diag_pkg::TX_LOAD;
        end
      end
      diag_pkg::TX_LOAD: begin
        state_d = diag_pkg::TX_SEND;
      end
      diag_pkg::TX_SEND: begin
        if (i_tx_ready) begin
          if (idx_q == `DIAG_TB_LAST) begin
            sent_done = 1'b1; // all 16 bytes gone
            state_d = diag_pkg::TX_IDLE;
          end else begin
            idx_d = idx_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = diag_pkg::TX_IDLE;
      end
    endcase
  end

  // registered stream outputs follow the next index
  always_comb begin
    valid_d = (state_d == diag_pkg::TX_SEND);
    data_d = valid_d ? snap_d[idx_d] : 8'h00;
    last_d = valid_d && (idx_d == `DIAG_TB_LAST);
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= diag_pkg::TX_IDLE;
      idx_q <= 4'h0;
      snap_q <= '0;
      valid_q <= 1'b0;
      data_q <= 8'h00;
      last_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      snap_q <= snap_d;
      valid_q <= valid_d;
      data_q <= data_d;
      last_q <= last_d;
    end
  end

  // ==========================================================================
  // outputs
  assign o_pi_rdata = rdata_q;
  assign o_pi_rvalid = rvalid_q;
  assign o_tx_valid = valid_q;
  assign o_tx_data = data_q;
  assign o_tx_last = last_q;
  assign o_diag_pending = pend_q;

endmodule
`default_nettype wire

// *** tb/diag_builder_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module diag_builder_monitor (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // process image
  input wire diag_pkg::pi_req_type i_pi,
  input wire logic [15:0] i_diag_base,
  input wire logic o_pi_rvalid,
  // telegram stream
  input wire logic i_diag_req,
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_last
);
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic hit;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  // a read is only answered inside the six-byte block
  assign hit = i_pi.rd && (i_pi.addr >= i_diag_base) && (i_pi.addr < i_diag_base + 16'h0006);

  // byte position; wraps to 0 after byte 15 so a new telegram starts clean
  always_comb begin
    idx_d = idx_q;
    if (o_tx_valid && i_tx_ready) begin
      idx_d = idx_q + 4'h1;
    end
    if (!o_tx_valid) begin
      idx_d = 4'h0;
    end
  end

  // position register
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_q <= 4'h0;
    end else begin
      idx_q <= idx_d;
    end
  end

  st1_fixed_a: assert property (o_tx_valid && idx_q == 4'h0 |-> (o_tx_data & 8'ha1) == 8'h00)
    else $error("station status 1 fixed bits wrong");
  st2_fixed_a: assert property (o_tx_valid && idx_q == 4'h1 |-> o_tx_data[7:6] == 2'b00 && o_tx_data[2])
    else $error("station status 2 fixed bits wrong");
  st3_reserved_a: assert property (o_tx_valid && idx_q == 4'h2 |-> o_tx_data[6:0] == 7'h00)
    else $error("station status 3 reserved bits set");
  dev_header_a: assert property (o_tx_valid && idx_q == 4'h6 |-> o_tx_data == 8'h0a)
    else $error("device header byte wrong");
  msg_code_a: assert property (o_tx_valid && idx_q == 4'h7 |-> o_tx_data inside {8'h00, [8'h12:8'h17], 8'h40})
    else $error("message code outside the defined set");
  reserved_bytes_a: assert property (o_tx_valid && idx_q inside {[4'h8:4'ha]} |-> o_tx_data == 8'h00)
    else $error("reserved telegram byte not zero");
  last_byte_a: assert property (o_tx_valid |-> o_tx_last == (idx_q == 4'hf))
    else $error("last flag not on byte 15");
  stall_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("byte dropped while link stalls");
  req_answer_a: assert property (i_diag_req && !o_tx_valid |-> ##[1:2] o_tx_valid)
    else $error("diagnostic request not answered");
  read_answer_a: assert property (hit |=> o_pi_rvalid)
    else $error("block read not answered");
  read_spurious_a: assert property (o_pi_rvalid |-> $past(hit))
    else $error("read answer without block hit");
endmodule

bind dp_slave_diag_builder diag_builder_monitor diag_builder_monitor_inst (
  .i_mclk(i_mclk),
  .i_arst_n(i_arst_n),
  .i_pi(i_pi),
  .i_diag_base(i_diag_base),
  .o_pi_rvalid(o_pi_rvalid),
  .i_diag_req(i_diag_req),
  .i_tx_ready(i_tx_ready),
  .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data),
  .o_tx_last(o_tx_last)
);

`default_nettype wire

// *** tb/dp_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module dp_master_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // control from the bench
  input wire logic i_go,
  input wire logic i_slow,
  // telegram from the slave
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_last,
  // requests and collected telegram
  output logic o_diag_req,
  output logic o_tx_ready,
  output diag_pkg::telegram_type o_tele,
  output logic o_done
);
  logic [3:0] idx;

  // slow mode stalls every other cycle to exercise byte holding
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_diag_req <= 1'b0;
      o_tx_ready <= 1'b0;
      o_done <= 1'b0;
      idx <= 4'h0;
      o_tele <= '0;
    end else begin
      o_diag_req <= i_go; // master asks for diagnostics
      o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
      o_done <= 1'b0;
      if (i_tx_valid && o_tx_ready) begin
        o_tele[idx] <= i_tx_data;
        idx <= idx + 4'h1;
        o_done <= i_tx_last;
      end
    end
  end
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [15:0] ID_VAL = 16'h5aa5; // arbitrary value
  logic [15:0] base;
  logic i_mclk, i_arst_n, o_pi_rvalid, prm, frz, syn, err, clr;
  logic req, rdy, o_tx_valid, o_tx_last, pend, go, slow, done;
  logic [7:0] o_pi_rdata, o_tx_data, err_code, mst, m_mst, m_msg, q;
  logic m_frz, m_syn, hit;
  logic [7:0] m_pay [1:5];
  diag_pkg::pi_req_type pi;
  diag_pkg::station_flags_type fl;
  diag_pkg::telegram_type tele;
  int fail_count, check_count;

  dp_slave_diag_builder #(.IDENT_NUM(ID_VAL)) dp_slave_diag_builder_inst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_pi(pi), .i_diag_base(base),
    .o_pi_rdata(o_pi_rdata), .o_pi_rvalid(o_pi_rvalid), .i_flags(fl), .i_prm_valid(prm),
    .i_prm_master(mst), .i_freeze_rx(frz), .i_sync_rx(syn), .i_err_valid(err),
    .i_err_code(err_code), .i_err_clear(clr), .i_diag_req(req), .i_tx_ready(rdy),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .o_diag_pending(pend));

  dp_master_model dp_master_model_inst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_go(go), .i_slow(slow), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .i_tx_last(o_tx_last), .o_diag_req(req), .o_tx_ready(rdy),
    .o_tele(tele), .o_done(done));

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one access; the answer pulse lasts a single cycle, so look every cycle
  task automatic pi_acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    hit = 1'b0;
    q = 8'h00;
    @(posedge i_mclk);
    pi <= '{wr: wr, rd: !wr, addr: base + a, wdata: d};
    @(posedge i_mclk);
    pi <= '0;
    repeat (3) begin
      #1;
      if (o_pi_rvalid === 1'b1 && !hit) begin
        hit = 1'b1;
        q = o_pi_rdata;
      end
      @(posedge i_mclk);
    end
  endtask

  task automatic ev(input logic [4:0] v);
    @(posedge i_mclk);
    {prm, frz, syn, err, clr} <= v;
    @(posedge i_mclk);
    {prm, frz, syn, err, clr} <= 5'h00;
  endtask

  function automatic diag_pkg::telegram_type exp_tele();
    diag_pkg::telegram_type t;
    t = '0;
    t[0] = {1'b0, fl.wrong_param, 1'b0, fl.unsupported, m_msg != 8'h00, fl.cfg_mismatch, fl.not_ready, 1'b0};
    t[1] = {2'b00, m_syn, m_frz, fl.resp_mon, 1'b1, fl.static_diag, fl.need_param};
    t[2] = {fl.overflow, 7'h00};
    t[3] = m_mst;
    t[4] = ID_VAL[15:8];
    t[5] = ID_VAL[7:0];
    t[6] = 8'h0a;
    t[7] = m_msg;
    for (int k = 1; k < 6; k++) t[10 + k] = m_pay[k];
    return t;
  endfunction

  // fetch one telegram through the master model and compare every byte
  task automatic fetch(input logic s, input string name);
    diag_pkg::telegram_type e;
    int k;
    e = exp_tele();
    @(posedge i_mclk);
    go <= 1'b1;
    slow <= s;
    @(posedge i_mclk);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    check("telegram done", {7'h00, done}, 8'h01);
    for (int i = 0; i < 16; i++) check("telegram byte", tele[i], e[i]);
    @(posedge i_mclk);
    #1;
    check("pending after send", {7'h00, pend}, 8'h00);
    $display("test %s done", name);
  endtask

  // ==========================================================================
  // clock, watchdog and tests
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    finish_test();
  end

  initial begin
    {i_arst_n, prm, frz, syn, err, clr, go, slow} = 8'h00;
    {pi, fl, mst, err_code} = '0;
    base = 16'h0100;
    {fail_count, check_count, m_frz, m_syn, m_msg} = '0;
    m_mst = 8'hff;
    for (int k = 1; k < 6; k++) m_pay[k] = 8'h00;
    repeat (10) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    pi_acc(1'b0, 16'h0000, 8'h00);
    check("status reset", q, 8'h00);
    fetch(1'b0, "reset");
    @(posedge i_mclk);
    fl <= 8'ha5; // uneven pattern so a swapped flag shows
    mst <= 8'h21;
    ev(5'h10);
    ev(5'h08); // freeze alone first, sync later, so the two bits cannot swap unseen
    {m_mst, m_frz, m_syn} = {8'h21, 2'b10};
    for (int k = 1; k < 6; k++) begin
      m_pay[k] = 8'h30 + 8'(k);
      pi_acc(1'b1, 16'(k), m_pay[k]);
    end
    pi_acc(1'b0, 16'h0005, 8'h00);
    check("user byte 5", q, 8'h35);
    pi_acc(1'b0, 16'h0006, 8'h00);
    check("outside read", {7'h00, hit}, 8'h00);
    pi_acc(1'b1, 16'h0000, 8'h01);
    m_msg = 8'h40;
    check("pending on start", {7'h00, pend}, 8'h01);
    fetch(1'b1, "user start");
    pi_acc(1'b1, 16'h0000, 8'h03);
    pi_acc(1'b0, 16'h0000, 8'h00);
    check("status ignored", q, 8'h01);
    ev(5'h04);
    m_syn = 1'b1;
    fetch(1'b0, "ignore");
    pi_acc(1'b1, 16'h0000, 8'h02);
    fl <= 8'h5a;
    m_msg = 8'h00;
    ev(5'h10);
    {m_frz, m_syn} = 2'b00;
    fetch(1'b0, "delete");
    for (int c = 8'h11; c < 8'h19; c++) begin
      @(posedge i_mclk);
      err_code <= 8'(c);
      ev(5'h02);
      m_msg = (c > 8'h11 && c < 8'h18) ? 8'(c) : 8'h00;
      #1;
      check("pending on error", {7'h00, pend}, {7'h00, m_msg != 8'h00});
      fetch(1'b0, "error code");
      ev(5'h01);
      m_msg = 8'h00;
    end
    // block moved to another base, then started and marked invalid again
    base <= 16'h0230;
    pi_acc(1'b1, 16'h0000, 8'h01);
    pi_acc(1'b0, 16'h0003, 8'h00);
    check("moved user byte 3", q, 8'h33);
    pi_acc(1'b1, 16'h0000, 8'h00);
    fetch(1'b0, "invalid");
    finish_test();
  end
endmodule

`default_nettype wire
